// ==== src/dio_pair.sv ====
// Purpose: Differential I/O pair with input, output and 3-state storage
// Assumes: Pins sampled synchronously to pclk; APB master per AMBA rules
// Notes:   Two-way pins split into input, output and output enable
//
// The register offsets and the APB register port were chosen for this implementation.

`timescale 1ns/1ps

// Function
// - Input storage only in true leg cell
// - Storage: flop or latch, enable, clear/preset/set/reset
// - Input takes true and complement, one output
// - Complement output inverse of true output, except on the registered path under local set/reset (sr_in), where both legs take the same value
// - Separate output register in each leg
// - Complement register receives inverted data
// - Output registers initialise to opposite values
// - Both legs share clock, enable, set/reset
// - Common 3-state control and enable for legs
// - Both 3-state registers initialise to same state
// - High impedance during global or local reset
// - 3-state register shares output clock enable
// - Bidirectional pair combines input and output paths
// - Unregistered output only on async-capable pairs
module dio_pair
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  true_in,
   input  wire logic [7:0]  complement_input,
   output logic             true_out,
   output logic             true_oe,
   output logic             complement_output,
   output logic             complement_oe
);

   dio_ctl_if ctl ();

   logic [31:0]                  ctrl_reg;
   logic [31:0]                  ctrl_next;
   logic [31:0]                  data_reg;
   logic [31:0]                  data_next;
   logic [31:0]                  prdata_reg;
   logic [31:0]                  prdata_next;
   logic                         pready_reg;
   logic                         pslverr_reg;
   dio_pkg::dio_apb_state_t      state_reg;
   dio_pkg::dio_apb_state_t      state_next;
   logic                         true_out_reg;
   logic                         true_oe_reg;
   logic                         comp_out_reg;
   logic                         comp_oe_reg;

   logic                         rx_bit;
   logic                         in_q;
   logic                         out_true_q;
   logic                         out_comp_q;
   logic                         tri_true_q;
   logic                         tri_comp_q;
   logic                         output_clock_enable;
   logic                         ice;
   logic                         out_d;
   logic                         tri_d;
   logic                         use_reg;
   logic                         sr_active;
   logic                         drive_true;
   logic                         drive_comp;
   logic                         en_true;
   logic                         en_comp;
   logic                         wr_hit;
   logic                         rd_phase;
   logic                         addr_ok;
   logic                         sel_ctrl;
   logic                         sel_data;
   logic                         sel_status;
   logic [31:0]                  status_word;

   // Differential receiver on an 8-bit sampled level per leg
   assign rx_bit = (true_in > complement_input);

   // Shared control bundle: one source for both legs and all elements
   assign ctl.mode.latch = ctrl_reg[dio_pkg::CTRL_LATCH_BIT];
   assign ctl.mode.sync  = ctrl_reg[dio_pkg::CTRL_SYNC_BIT];
   assign ctl.mode.setv  = ctrl_reg[dio_pkg::CTRL_SETV_BIT];
   assign ctl.global_set_reset        = ctrl_reg[dio_pkg::CTRL_GSR_BIT];
   assign ctl.sr_in      = ctrl_reg[dio_pkg::CTRL_SRIN_BIT];

   assign output_clock_enable       = data_reg[dio_pkg::DATA_OCE_BIT];
   assign ice       = data_reg[dio_pkg::DATA_ICE_BIT];
   assign out_d     = data_reg[dio_pkg::DATA_OUT_BIT];
   assign tri_d     = data_reg[dio_pkg::DATA_TRI_BIT];
   assign sr_active = ctl.global_set_reset | ctl.sr_in;

   // Unregistered drive is only honoured on async-capable pairs
   assign use_reg = ctrl_reg[dio_pkg::CTRL_OREG_BIT] |
                    ~ctrl_reg[dio_pkg::CTRL_ASYNC_BIT];

   // Input storage lives in the true-leg cell only
   dio_store #(.INIT(1'b0)) u_in_true
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl),
      .en      (ice),
      .d       (rx_bit),
      .q       (in_q)
   );

   // Output data registers: one per leg, opposite power-up values
   dio_store #(.INIT(1'b0)) u_out_true
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl),
      .en      (output_clock_enable),
      .d       (out_d),
      .q       (out_true_q)
   );

   dio_store #(.INIT(1'b1)) u_out_comp
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl),
      .en      (output_clock_enable),
      .d       (~out_d),
      .q       (out_comp_q)
   );

   // 3-state registers: same enable as output data, same power-up state;
   // any set/reset parks them at Z until the next enabled edge reloads them
   dio_store #(.INIT(1'b1), .SR_INIT(1'b1)) u_tri_true
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl),
      .en      (output_clock_enable),
      .d       (tri_d),
      .q       (tri_true_q)
   );

   dio_store #(.INIT(1'b1), .SR_INIT(1'b1)) u_tri_comp
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl),
      .en      (output_clock_enable),
      .d       (tri_d),
      .q       (tri_comp_q)
   );

   // Complement leg data is the inverse of the true leg on the unregistered path
   assign drive_true = use_reg ? out_true_q : out_d;
   assign drive_comp = use_reg ? out_comp_q : ~out_d;

   // High impedance under any set/reset, else the 3-state value
   assign en_true = ~sr_active & ~(use_reg ? tri_true_q : tri_d);
   assign en_comp = ~sr_active & ~(use_reg ? tri_comp_q : tri_d);

   // Register decode shared by the write, read and error paths
   function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
      return addr == offset;
   endfunction

   // APB decode; one wait-free access phase
   assign sel_ctrl   = reg_hit(paddr, dio_pkg::OFF_CTRL);
   assign sel_data   = reg_hit(paddr, dio_pkg::OFF_DATA);
   assign sel_status = reg_hit(paddr, dio_pkg::OFF_STATUS);
   assign addr_ok    = sel_ctrl | sel_data | sel_status;
   assign wr_hit     = psel && penable && pready_reg && pwrite && addr_ok;
   assign rd_phase   = psel && !penable && !pwrite;

   // Status shows the pair's own state
   assign status_word = {26'h000_0000, en_comp, en_true, drive_comp,
                         drive_true, rx_bit, in_q};

   // Write path: registers change only at the access edge that shows pready,
   // so a request dropped after its setup cycle leaves them untouched
   assign ctrl_next = (wr_hit && sel_ctrl) ? pwdata : ctrl_reg;
   assign data_next = (wr_hit && sel_data) ? pwdata : data_reg;

   // Read data selected at setup, held through the access phase
   assign prdata_next = !rd_phase ? prdata_reg :
                        sel_ctrl                       ? ctrl_reg :
                        sel_data                       ? data_reg :
                        sel_status                     ? status_word :
                        32'h0000_0000;

   // Two-state slave: setup seen, then answer in the access phase
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         dio_pkg::DIO_IDLE:
            if (psel && !penable)
               state_next = dio_pkg::DIO_ACCESS;
         dio_pkg::DIO_ACCESS:
            state_next = dio_pkg::DIO_IDLE;
         default:
            state_next = dio_pkg::DIO_IDLE;
      endcase
   end

   // Register file and bus answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg    <= dio_pkg::CTRL_RESET;
         data_reg    <= dio_pkg::DATA_RESET;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         state_reg   <= dio_pkg::DIO_IDLE;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         data_reg    <= data_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= (state_next == dio_pkg::DIO_ACCESS);
         pslverr_reg <= (state_next == dio_pkg::DIO_ACCESS) && !addr_ok;
         state_reg   <= state_next;
      end
   end

   // Pin outputs re-timed so every top output comes from a flip-flop;
   // both legs move on the same edge, so complementarity is kept
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         true_out_reg <= 1'b0;
         comp_out_reg <= 1'b1;
         true_oe_reg  <= 1'b0;
         comp_oe_reg  <= 1'b0;
      end
      else
      begin
         true_out_reg <= drive_true;
         comp_out_reg <= drive_comp;
         true_oe_reg  <= en_true;
         comp_oe_reg  <= en_comp;
      end
   end

   assign prdata            = prdata_reg;
   assign pready            = pready_reg;
   assign pslverr           = pslverr_reg;
   assign true_out          = true_out_reg;
   assign complement_output = comp_out_reg;
   assign true_oe           = true_oe_reg;
   assign complement_oe     = comp_oe_reg;

endmodule

// ==== src/dio_pkg.sv ====
// Purpose: Shared constants and types for the differential I/O pair block
// Assumes: One clock (pclk), APB register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words

package dio_pkg;

   // Register byte offsets
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_DATA   = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;

   // Control field positions
   localparam int CTRL_LATCH_BIT = 0;  // 1: transparent latch, 0: edge flip-flop
   localparam int CTRL_SYNC_BIT  = 1;  // 1: synchronous reset/set, 0: asynchronous
   localparam int CTRL_SETV_BIT  = 2;  // 1: set/preset, 0: reset/clear
   localparam int CTRL_OREG_BIT  = 3;  // 1: registered output path
   localparam int CTRL_ASYNC_BIT = 4;  // 1: pair is capable of asynchronous drive
   localparam int CTRL_GSR_BIT   = 5;  // Global set/reset request
   localparam int CTRL_SRIN_BIT  = 6;  // Set/reset input level

   // Data register field positions
   localparam int DATA_OUT_BIT = 0;    // Output data
   localparam int DATA_TRI_BIT = 1;    // 3-state control, 1 = high impedance
   localparam int DATA_OCE_BIT = 2;    // Output clock enable (shared with 3-state)
   localparam int DATA_ICE_BIT = 3;    // Input clock / gate enable

   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
   localparam logic [31:0] DATA_RESET = 32'h0000_0006;

   // Storage element behaviour set
   typedef struct packed {
      logic latch;
      logic sync;
      logic setv;
   } dio_mode_t;

   // APB slave states
   typedef enum logic [1:0] {
      DIO_IDLE   = 2'b01,
      DIO_ACCESS = 2'b10
   } dio_apb_state_t;

endpackage

// ==== src/dio_ctl_if.sv ====
// Purpose: Shared control bundle for the pair's storage elements
// Assumes: One driver (top) and many storage elements
// Notes:   One source for storage mode and set/reset keeps both legs in step

`timescale 1ns/1ps

interface dio_ctl_if;
   dio_pkg::dio_mode_t mode;
   logic               global_set_reset;
   logic               sr_in;

   modport src
   (
      output mode,
      output global_set_reset,
      output sr_in
   );
   modport sink
   (
      input  mode,
      input  global_set_reset,
      input  sr_in
   );
endinterface

// ==== src/dio_store.sv ====
// Purpose: One configurable storage element of an I/O cell
// Assumes: Enable is a gate enable in latch mode, a clock enable otherwise
// Notes:   Latch mode is modelled as transparent while the enable is high

`timescale 1ns/1ps

module dio_store
#(
   parameter logic INIT    = 1'b0,
   parameter logic SR_INIT = 1'b0   // 1: every set/reset restores INIT (3-state cells)
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   dio_ctl_if.sink   ctl,
   input  wire logic en,
   input  wire logic d,
   output logic      q
);

   logic q_reg;
   logic hold_sr;
   logic async_sr;
   logic sr_val;

   // Asynchronous set/reset acts at once; synchronous form waits for the edge
   assign async_sr = ctl.global_set_reset | (ctl.sr_in & ~ctl.mode.sync);
   assign hold_sr  = ctl.global_set_reset | ctl.sr_in;
   // 3-state cells park at INIT (Z) so released legs never drive equal levels
   assign sr_val   = SR_INIT ? INIT : ctl.mode.setv;

   // Global set/reset restores the power-up value; sr_in forces set or clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q_reg <= INIT;
      else if (ctl.global_set_reset)
         q_reg <= INIT;
      else if (hold_sr)
         q_reg <= sr_val;
      else if (en)
         q_reg <= d;
   end

   // Latch mode passes data while enabled; flip-flop holds until the edge
   assign q = (ctl.mode.latch && en && !hold_sr) ? d :
              (async_sr && !ctl.global_set_reset) ? sr_val :
              (ctl.global_set_reset ? INIT : q_reg);

endmodule

// ==== test/dio_pair_asserts.sv ====
// Purpose: Port-level checks for the differential pair block
// Assumes: One clock, zero-wait APB, registered pins
// Notes:   Shadows CTRL and DATA writes to know the active mode
`timescale 1ns/1ps
module dio_pair_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        true_out,
   input wire logic        true_oe,
   input wire logic        complement_output,
   input wire logic        complement_oe
);
   logic [6:0] ctrl_sh;
   logic       oce_sh;
   wire        setup  = psel && !penable;
   wire        done   = psel && penable && pready;
   wire        mapped = paddr inside {12'h000, 12'h004, 12'h008};
   wire        quiet  = !oce_sh && ctrl_sh == 7'h08;
   wire        forced = ctrl_sh[5] || ctrl_sh[6];
   // Mode shadow updates at the same edge as the write takes effect
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ctrl_sh <= 7'h08;
         oce_sh  <= 1'b1;
      end
      else if (done && pwrite && paddr == 12'h000)
         ctrl_sh <= pwdata[6:0];
      else if (done && pwrite && paddr == 12'h004)
         oce_sh <= pwdata[2];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_LEGS_INV: assert property (true_oe |-> complement_output != true_out)
      else $error("legs not inverse");
   AST_OE_SAME: assert property (true_oe == complement_oe)
      else $error("leg enables differ");
   AST_RST_INIT: assert property ($rose(presetn) |-> !true_oe && !true_out && complement_output)
      else $error("wrong initial pin state");
   AST_WR_PINS: assert property (done && pwrite && paddr == 12'h004 && pwdata[2]
      && ctrl_sh == 7'h08 |-> ##3 true_out == $past(pwdata[0], 3)
      && true_oe == !$past(pwdata[1], 3))
      else $error("pins do not follow data write");
   AST_OCE_HOLD: assert property (quiet [*3] |-> $stable(true_out) && $stable(true_oe))
      else $error("pins moved with enable low");
   AST_FORCE_Z: assert property (forced [*3] |-> !true_oe && !complement_oe)
      else $error("pins driven during set or reset");
   AST_PREADY: assert property (setup |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   AST_SLVERR: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   AST_UNMAP_RD: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   COV_WR: cover property (setup && pwrite && paddr == 12'h004 && ctrl_sh == 7'h08);
   COV_FORCE: cover property (forced [*3]);
   COV_ERR: cover property (pready && pslverr);
endmodule
bind dio_pair dio_pair_chk dio_pair_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .true_out, .true_oe, .complement_output,
   .complement_oe);

// ==== test/dio_lvds_peer.sv ====
// Purpose: Far-side differential driver feeding the pair's input legs
// Assumes: Leg levels are 8-bit numbers, higher means more positive
// Notes:   Released lines wander so a stale level is never mistaken for data
`timescale 1ns/1ps
module dio_lvds_peer
(
   input  wire logic       pclk,
   input  wire logic       drive,
   input  wire logic       bit_v,
   input  wire logic [6:0] mag,
   output logic      [7:0] true_in,
   output logic      [7:0] complement_input
);
   logic [7:0] wander_reg = 8'h00;
   wire  [7:0] hi = {1'b1, mag};
   wire  [7:0] lo = {1'b0, ~mag};
   // Pattern moves every cycle while not driving
   always_ff @(posedge pclk)
      wander_reg <= wander_reg + 8'h53;
   // Driven leg sits above the other by a random margin
   assign true_in          = drive ? (bit_v ? hi : lo) : wander_reg;
   assign complement_input = drive ? (bit_v ? lo : hi) : ~wander_reg;
endmodule

// ==== test/test_dio_pair.sv ====
// Purpose: Self-checking bench for the differential pair block
// Assumes: Zero-wait APB slave, STATUS mirrors pins and input storage
// Notes:   Reads are checked by a monitor against queued notes
`timescale 1ns/1ps
module test_dio_pair;
   typedef struct packed {logic [32:0] v; logic [32:0] m;} dio_note_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, true_out, true_oe, complement_output, complement_oe;
   logic [7:0]  true_in, complement_input;
   wire  [3:0]  pins = {true_oe, complement_oe, complement_output, true_out};
   logic        peer_drive = 1, rx_bit = 0, b, rb, ice, q = 0;
   logic [6:0]  rx_mag = 0;
   int          err_count = 0, comparisons = 0;
   dio_note_t   notes[$], nt;
   logic [31:0] modes [5] = '{32'h0000_0008, 32'h0000_0009, 32'h0000_0018, 32'h0000_0010,
                              32'h0000_0000};
   logic [31:0] forces [5] = '{32'h0000_0028, 32'h0000_0048, 32'h0000_004C, 32'h0000_004A,
                               32'h0000_004E};
   dio_pair dio_pair_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .true_in, .complement_input, .true_out, .true_oe,
      .complement_output, .complement_oe);
   dio_lvds_peer dio_lvds_peer_inst (.pclk, .drive(peer_drive), .bit_v(rx_bit), .mag(rx_mag),
      .true_in, .complement_input);
   // Free-running clock, 5 ns period
   initial
      forever #2.5 pclk = ~pclk;
   task automatic results();
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] v, input logic [32:0] m);
      notes.push_back('{v, m});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // Status word: enables, leg drives, receiver bit, input storage
   function automatic logic [32:0] st(input logic sq, input logic srx, input logic t,
                                      input logic oe);
      return {27'h0, oe, oe, ~t, t, srx, sq};
   endfunction
   task automatic idle();
      repeat (4) @(posedge pclk);
   endtask
   // Monitor: every completed read is compared with the oldest note
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         nt = notes.pop_front();
         check({pslverr, prdata} & nt.m, nt.v & nt.m);
      end
   // Watchdog far above the expected run length
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      results();
   end
   initial
   begin
      void'($urandom(25));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of registers and pins, then refused accesses
      rd(12'h000, 33'h0_0000_0008, '1);
      rd(12'h004, 33'h0_0000_0006, '1);
      rd(12'h008, st(0, 0, 0, 0), '1);
      apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
      rd(12'hFFC, 33'h1_0000_0000, '1);
      rd(12'h000, 33'h0_0000_0008, '1);
      // Flop and latch storage, registered and unregistered drive, back-to-back data writes, random receiver levels
      for (int i = 0; i < 10; i++)
      begin
         b = 1'($urandom);
         rb = 1'($urandom);
         rx_bit <= rb;
         rx_mag <= 7'($urandom);
         ice = (i >= 5);
         if (ice)
            q = rb;
         apb(1'b1, 12'h000, modes[i % 5]);
         apb(1'b1, 12'h004, {28'h0, ice, 2'b10, ~b});
         apb(1'b1, 12'h004, {28'h0, ice, 2'b10, b});
         idle();
         check({29'h0, pins}, {29'h0, 2'b11, ~b, b});
         rd(12'h008, st(q, rb, b, 1), '1);
      end
      // Enable low holds both data and 3-state storage
      apb(1'b1, 12'h004, 32'h0000_0003);
      idle();
      check({29'h0, pins}, {29'h0, 2'b11, ~b, b});
      rd(12'h008, st(q, rb, b, 1), '1);
      apb(1'b1, 12'h004, 32'h0000_0006);
      idle();
      check({29'h0, pins}, 33'h2);
      rd(12'h008, st(q, rb, 0, 0), '1);
      // Global and local set/reset force high impedance; far side released
      peer_drive <= 1'b0;
      apb(1'b1, 12'h004, 32'h0000_0005);
      for (int j = 0; j < 5; j++)
      begin
         apb(1'b1, 12'h000, forces[j]);
         idle();
         check({31'h0, pins[3:2]}, 33'h0);
         rd(12'h008, 33'h08, (j == 0) ? 33'h3D : 33'h30);
         apb(1'b1, 12'h000, 32'h0000_0008);
         idle();
         check({29'h0, pins}, 33'hD);
         rd(12'h008, st(0, 0, 1, 1), 33'h3C);
      end
      // Reset in mid-run returns the legs to opposite levels, enables off
      peer_drive <= 1'b1;
      presetn    <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn    <= 1'b1;
      check({30'h0, pins[3], pins[1:0]}, 33'h2);
      rd(12'h004, 33'h0_0000_0006, '1);
      rd(12'h008, 33'h08, 33'h3D);
      idle();
      results();
   end
endmodule
